// ---- hdl/spipc_top.sv ----
// Serial data path with pin-function control and an Avalon-MM register slave.
// Assumes one core clock; the serial clock pin is sampled, never used as a clock.
// Fixed clock scheme: idle low, sample on rising edge, shift on falling edge.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module spipc_top
  import spipc_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Select pin
  input wire logic sel_pin_in,
  output logic sel_pin_out,
  output logic sel_pin_oe,
  // Clock pin
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  // Master-out pin
  input wire logic mosi_pin_in,
  output logic mosi_pin_out,
  output logic mosi_pin_oe,
  // Master-in pin
  input wire logic miso_pin_in,
  output logic miso_pin_out,
  output logic miso_pin_oe
);

  // Bus handshake
  spipc_bus_state_t bus_state_q; // Idle or answering
  logic [31:0] readdata_q; // Registered read data
  logic waitrequest_q; // High except in the answer cycle
  logic [31:0] read_mux; // Read value for the current address
  logic acc_wr; // Write takes effect this edge
  logic acc_rd; // Read completes this edge
  logic wr_lane0; // Low byte lane enabled

  // Software-visible state
  logic master_q; // Role, 1 is master
  logic transmit_output_enable_q; // Transmit output enable
  logic done_q; // Transfer-done flag
  logic [7:0] pc_sc_q; // Select and clock pin control, writable bits
  logic [7:0] pc_dt_q; // Data pin control, writable bits
  logic [7:0] rx_buf_q; // Receive buffer
  logic [7:0] shift_q; // Shift register

  // Serial engine
  logic busy_q; // Master transfer running
  logic [3:0] div_q; // Master half-period counter
  logic sclk_q; // Master serial clock level
  logic [3:0] bit_cnt_q; // Falling edges seen in this character
  logic sample_q; // Bit captured on rising edge
  logic sclk_prev_q; // Last synchronised clock pin level
  logic ev_rise; // Sample point
  logic ev_fall; // Shift point
  logic m_rise; // Master clock about to rise
  logic m_fall; // Master clock about to fall
  logic rx_bit; // Incoming data level
  logic slave_selected; // Slave takes part in the transfer
  logic load_ok; // Shift register may accept a write
  logic char_done; // Eighth shift this cycle

  // Pins
  logic [NUM_PINS-1:0] pin_raw; // Raw pin levels
  logic [NUM_PINS-1:0] pin_lvl; // Synchronised pin levels
  logic [NUM_PINS-1:0] p_ser_sel; // Serial function owns the pin
  logic [NUM_PINS-1:0] p_ser_oe; // Serial drive enable
  logic [NUM_PINS-1:0] p_ser_out; // Serial drive value
  logic [NUM_PINS-1:0] p_dir; // General-purpose direction
  logic [NUM_PINS-1:0] p_val; // General-purpose value
  logic [NUM_PINS-1:0] p_out_q; // Registered drive value
  logic [NUM_PINS-1:0] p_oe_q; // Registered drive enable

  assign pin_raw[PIN_SEL] = sel_pin_in;
  assign pin_raw[PIN_CLK] = clk_pin_in;
  assign pin_raw[PIN_MOSI] = mosi_pin_in;
  assign pin_raw[PIN_MISO] = miso_pin_in;

  // Pin levels pass two flops before any logic reads them
  spipc_sync #(
    .W(NUM_PINS)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .async_in(pin_raw),
    .sync_out(pin_lvl)
  );

  // Access strobes, valid only while the master holds its request
  assign acc_wr = avs_write && (bus_state_q == SPIPC_BUS_ANSWER);
  assign acc_rd = avs_read && (bus_state_q == SPIPC_BUS_ANSWER);
  assign wr_lane0 = acc_wr && avs_byteenable[0];

  // Read value; live pin levels merged into bits 7 and 3
  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (avs_address)
      ADDR_CONTROL: begin
        read_mux[CTL_MASTER_BIT] = master_q;
        read_mux[CTL_TRANSMIT_OUTPUT_ENABLE_BIT] = transmit_output_enable_q;
      end
      ADDR_STATUS: read_mux[STS_DONE_BIT] = done_q;
      ADDR_RX_BUF: read_mux[7:0] = rx_buf_q;
      ADDR_SHIFT: read_mux[7:0] = shift_q;
      ADDR_PC_SEL_CLK: begin
        read_mux[7:0] = pc_sc_q & PC_WRITE_MASK;
        read_mux[PC_HI_LEVEL] = pin_lvl[PIN_SEL];
        read_mux[PC_LO_LEVEL] = pin_lvl[PIN_CLK];
      end
      ADDR_PC_DATA: begin
        read_mux[7:0] = pc_dt_q & PC_WRITE_MASK;
        read_mux[PC_HI_LEVEL] = pin_lvl[PIN_MOSI];
        read_mux[PC_LO_LEVEL] = pin_lvl[PIN_MISO];
      end
      default: read_mux = 32'h0000_0000; // Unmapped reads as zero
    endcase
  end

  // Bus handshake: one wait cycle, then one answer cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_state_q <= SPIPC_BUS_IDLE;
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h0000_0000;
    end else if (ce) begin
      unique case (bus_state_q)
        SPIPC_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            readdata_q <= read_mux;
            waitrequest_q <= 1'b0;
            bus_state_q <= SPIPC_BUS_ANSWER;
          end
        end
        SPIPC_BUS_ANSWER: begin
          // Back to idle so a released request is never answered twice
          waitrequest_q <= 1'b1;
          bus_state_q <= SPIPC_BUS_IDLE;
        end
      endcase
    end
  end

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitrequest_q;

  // Role and transmit enable; reset leaves a silent slave
  always_ff @(posedge core_clk) begin
    if (rst) begin
      master_q <= 1'b0;
      transmit_output_enable_q <= 1'b0;
    end else if (ce && wr_lane0 && avs_address == ADDR_CONTROL) begin
      master_q <= avs_writedata[CTL_MASTER_BIT];
      transmit_output_enable_q <= avs_writedata[CTL_TRANSMIT_OUTPUT_ENABLE_BIT];
    end
  end

  // Pin control; level bits are never stored, so writes to them vanish
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_sc_q <= PC_RESET;
      pc_dt_q <= PC_RESET;
    end else if (ce && wr_lane0) begin
      if (avs_address == ADDR_PC_SEL_CLK) begin
        pc_sc_q <= avs_writedata[7:0] & PC_WRITE_MASK;
      end
      if (avs_address == ADDR_PC_DATA) begin
        pc_dt_q <= avs_writedata[7:0] & PC_WRITE_MASK;
      end
    end
  end

  // Slave takes part when select is unused or held low
  assign slave_selected = !pc_sc_q[PC_HI_FN] || !pin_lvl[PIN_SEL];

  // Master sees the master-in pin, slave the master-out pin, whatever their function
  assign rx_bit = master_q ? pin_lvl[PIN_MISO] : pin_lvl[PIN_MOSI];

  // Master clock edges fall due at the end of each half period
  assign m_rise = busy_q && (div_q == SCLK_HALF_CYC - 4'h1) && !sclk_q;
  assign m_fall = busy_q && (div_q == SCLK_HALF_CYC - 4'h1) && sclk_q;

  // Unified edge events for both roles
  assign ev_rise = master_q ? m_rise : (slave_selected && pin_lvl[PIN_CLK] && !sclk_prev_q);
  assign ev_fall = master_q ? m_fall : (slave_selected && !pin_lvl[PIN_CLK] && sclk_prev_q);
  assign char_done = ev_fall && (bit_cnt_q == LAST_BIT);

  // Writes mid-character are dropped so a frame is never torn
  assign load_ok = !busy_q && (bit_cnt_q == 4'h0) && !ev_fall;

  // Master transfer control and clock generator
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      div_q <= 4'h0;
      sclk_q <= 1'b0;
    end else if (ce) begin
      if (!busy_q) begin
        div_q <= 4'h0;
        sclk_q <= 1'b0;
        if (master_q && wr_lane0 && avs_address == ADDR_SHIFT && load_ok) begin
          busy_q <= 1'b1;
        end
      end else if (div_q == SCLK_HALF_CYC - 4'h1) begin
        div_q <= 4'h0;
        sclk_q <= !sclk_q;
        if (char_done) begin
          busy_q <= 1'b0;
        end
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  // Edge detector history for the synchronised clock pin
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
    end else if (ce) begin
      sclk_prev_q <= pin_lvl[PIN_CLK];
    end
  end

  // Sample on the rising edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_q <= 1'b0;
    end else if (ce && ev_rise) begin
      sample_q <= rx_bit;
    end
  end

  // Shift register: load on write, shift MSB out and LSB in on falling edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
    end else if (ce) begin
      if (ev_fall) begin
        shift_q <= {shift_q[CHAR_BITS-2:0], sample_q};
        bit_cnt_q <= char_done ? 4'h0 : bit_cnt_q + 4'h1;
      end else if (wr_lane0 && avs_address == ADDR_SHIFT && load_ok) begin
        shift_q <= avs_writedata[7:0];
      end
    end
  end

  // Completed character lands right justified in the buffer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_buf_q <= 8'h00;
    end else if (ce && char_done) begin
      rx_buf_q <= {shift_q[CHAR_BITS-2:0], sample_q};
    end
  end

  // Done flag: a new character wins over a simultaneous buffer read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (ce) begin
      if (char_done) begin
        done_q <= 1'b1;
      end else if (acc_rd && avs_address == ADDR_RX_BUF) begin
        done_q <= 1'b0;
      end
    end
  end

  // Pin function resolution, select pin
  always_comb begin
    // Master ignores the function bit; slave module select is never driven
    p_ser_sel[PIN_SEL] = !master_q && pc_sc_q[PC_HI_FN];
    p_ser_oe[PIN_SEL] = 1'b0;
    p_ser_out[PIN_SEL] = 1'b0;
    p_dir[PIN_SEL] = pc_sc_q[PC_HI_DIR];
    p_val[PIN_SEL] = pc_sc_q[PC_HI_OUT];
    // Clock pin: driven only by the master in serial function
    p_ser_sel[PIN_CLK] = pc_sc_q[PC_LO_FN];
    p_ser_oe[PIN_CLK] = master_q;
    p_ser_out[PIN_CLK] = sclk_q;
    p_dir[PIN_CLK] = pc_sc_q[PC_LO_DIR];
    p_val[PIN_CLK] = pc_sc_q[PC_LO_OUT];
    // Master-out pin: master drives data whenever transmit output enable is set, idle or not
    p_ser_sel[PIN_MOSI] = pc_dt_q[PC_HI_FN];
    p_ser_oe[PIN_MOSI] = master_q && transmit_output_enable_q;
    p_ser_out[PIN_MOSI] = shift_q[CHAR_BITS-1];
    p_dir[PIN_MOSI] = pc_dt_q[PC_HI_DIR];
    p_val[PIN_MOSI] = pc_dt_q[PC_HI_OUT];
    // Master-in pin: selected slave drives data while talking
    p_ser_sel[PIN_MISO] = pc_dt_q[PC_LO_FN];
    p_ser_oe[PIN_MISO] = !master_q && transmit_output_enable_q && slave_selected;
    p_ser_out[PIN_MISO] = shift_q[CHAR_BITS-1];
    p_dir[PIN_MISO] = pc_dt_q[PC_LO_DIR];
    p_val[PIN_MISO] = pc_dt_q[PC_LO_OUT];
  end

  // One registered driver per pin
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      spipc_pin_cell u_cell (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .serial_sel(p_ser_sel[gp]),
        .ser_oe(p_ser_oe[gp]),
        .ser_out(p_ser_out[gp]),
        .gpio_dir(p_dir[gp]),
        .gpio_out(p_val[gp]),
        .pin_out_q(p_out_q[gp]),
        .pin_oe_q(p_oe_q[gp])
      );
    end
  endgenerate

  assign sel_pin_out = p_out_q[PIN_SEL];
  assign sel_pin_oe = p_oe_q[PIN_SEL];
  assign clk_pin_out = p_out_q[PIN_CLK];
  assign clk_pin_oe = p_oe_q[PIN_CLK];
  assign mosi_pin_out = p_out_q[PIN_MOSI];
  assign mosi_pin_oe = p_oe_q[PIN_MOSI];
  assign miso_pin_out = p_out_q[PIN_MISO];
  assign miso_pin_oe = p_oe_q[PIN_MISO];

endmodule : spipc_top

// ---- hdl/spipc_pkg.sv ----
// Shared constants and types for the serial data path and pin control block.
// Assumes a 20 MHz core clock and word-aligned register slots on the bus.
package spipc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [14:0] IDX_CONTROL = 15'h7041;
  localparam logic [14:0] IDX_STATUS = 15'h7042;
  localparam logic [14:0] IDX_RX_BUF = 15'h7047;
  localparam logic [14:0] IDX_SHIFT = 15'h7049;
  localparam logic [14:0] IDX_PC_SEL_CLK = 15'h704D;
  localparam logic [14:0] IDX_PC_DATA = 15'h704E;
  localparam int ADDR_W = 17;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_RX_BUF = {IDX_RX_BUF, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SHIFT = {IDX_SHIFT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PC_SEL_CLK = {IDX_PC_SEL_CLK, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PC_DATA = {IDX_PC_DATA, 2'h0};

  // Control register fields
  localparam int CTL_MASTER_BIT = 2;
  localparam int CTL_TRANSMIT_OUTPUT_ENABLE_BIT = 1;
  // Status register fields
  localparam int STS_DONE_BIT = 6;

  // Pin control fields, identical layout in both port registers
  localparam int PC_HI_LEVEL = 7;
  localparam int PC_HI_OUT = 6;
  localparam int PC_HI_FN = 5;
  localparam int PC_HI_DIR = 4;
  localparam int PC_LO_LEVEL = 3;
  localparam int PC_LO_OUT = 2;
  localparam int PC_LO_FN = 1;
  localparam int PC_LO_DIR = 0;
  localparam logic [7:0] PC_WRITE_MASK = 8'h77;
  localparam logic [7:0] PC_RESET = 8'h00;

  // Pin numbering
  localparam int NUM_PINS = 4;
  localparam int PIN_SEL = 0;
  localparam int PIN_CLK = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_MISO = 3;

  // Character and timing
  localparam int CHAR_BITS = 8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS = 200;
  localparam logic [3:0] SCLK_HALF_CYC = 4'((SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Bus handshake states
  typedef enum logic {
    SPIPC_BUS_IDLE,
    SPIPC_BUS_ANSWER
  } spipc_bus_state_t;

endpackage : spipc_pkg

// ---- hdl/spipc_sync.sv ----
// Two-flop synchroniser for the pin inputs.
// Assumes each bit is an independent level from outside the core clock domain.
`timescale 1ns/1ps
module spipc_sync
  import spipc_pkg::*;
#(
  parameter int W = NUM_PINS
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q; // First stage, read only by second stage

  // One two-stage chain per bit
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge core_clk) begin
        if (rst) begin
          meta_q[gi] <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else if (ce) begin
          meta_q[gi] <= async_in[gi];
          sync_out[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule : spipc_sync

// ---- hdl/spipc_pin_cell.sv ----
// One pin driver: chooses serial function or general-purpose I/O.
// Assumes the caller has already resolved which function owns the pin.
`timescale 1ns/1ps
module spipc_pin_cell
  import spipc_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Function select
  input wire logic serial_sel,
  input wire logic ser_oe,
  input wire logic ser_out,
  // General-purpose settings
  input wire logic gpio_dir,
  input wire logic gpio_out,
  // Pin drive
  output logic pin_out_q,
  output logic pin_oe_q
);

  // Registered so the pin drive never glitches on mux changes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else if (ce) begin
      if (serial_sel) begin
        pin_out_q <= ser_out;
        pin_oe_q <= ser_oe;
      end else begin
        pin_out_q <= gpio_out;
        pin_oe_q <= gpio_dir;
      end
    end
  end

endmodule : spipc_pin_cell

// ---- tb/spipc_properties.sv ----
// Checker: bus handshake and pin drive against a shadow of the written settings.
// Assumes it is bound to spipc_top and sees only its ports.
`timescale 1ns/1ps
module spipc_properties
  import spipc_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Bus
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Pin drives
  input wire logic sel_pin_out,
  input wire logic sel_pin_oe,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  input wire logic mosi_pin_out,
  input wire logic mosi_pin_oe,
  input wire logic miso_pin_out,
  input wire logic miso_pin_oe
);
  logic [7:0] ctl_q, pc1_q, pc2_q; // Shadow settings
  logic done_wr; // Write takes effect at this edge
  logic mst; // Master role
  logic [17:0] cfg; // All settings, for stability tests
  assign done_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign mst = ctl_q[CTL_MASTER_BIT];
  assign cfg = {ctl_q[2:1], pc1_q, pc2_q};
  // Follow completed writes; level bits are never stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_q <= 8'h00;
      pc1_q <= 8'h00;
      pc2_q <= 8'h00;
    end else if (ce && done_wr) begin
      if (avs_address == ADDR_CONTROL) ctl_q <= avs_writedata[7:0];
      if (avs_address == ADDR_PC_SEL_CLK) pc1_q <= avs_writedata[7:0] & PC_WRITE_MASK;
      if (avs_address == ADDR_PC_DATA) pc2_q <= avs_writedata[7:0] & PC_WRITE_MASK;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || !ce);
  a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_wait_single_low: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_pc_readback: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_PC_SEL_CLK
    |-> (avs_readdata[7:0] & PC_WRITE_MASK) == pc1_q) else $error("pin ctl 1 readback wrong");
  a_sel_module_quiet: assert property ((!mst && pc1_q[PC_HI_FN]) [*2] |-> !sel_pin_oe)
    else $error("select pin driven as module select");
  a_sel_gpio_drive: assert property ($stable(cfg) && (mst || !pc1_q[PC_HI_FN]) |->
    sel_pin_oe == pc1_q[PC_HI_DIR] && (!sel_pin_oe || sel_pin_out == pc1_q[PC_HI_OUT]))
    else $error("select pin drive wrong");
  a_clk_gpio_drive: assert property ($stable(cfg) && !pc1_q[PC_LO_FN] |->
    clk_pin_oe == pc1_q[PC_LO_DIR] && (!clk_pin_oe || clk_pin_out == pc1_q[PC_LO_OUT]))
    else $error("clock pin drive wrong");
  a_clk_slave_quiet: assert property ($stable(cfg) && !mst && pc1_q[PC_LO_FN] |-> !clk_pin_oe)
    else $error("slave drives clock");
  a_mosi_gpio_drive: assert property ($stable(cfg) && !pc2_q[PC_HI_FN] |->
    mosi_pin_oe == pc2_q[PC_HI_DIR] && (!mosi_pin_oe || mosi_pin_out == pc2_q[PC_HI_OUT]))
    else $error("master-out pin drive wrong");
  a_miso_gpio_drive: assert property ($stable(cfg) && !pc2_q[PC_LO_FN] |->
    miso_pin_oe == pc2_q[PC_LO_DIR] && (!miso_pin_oe || miso_pin_out == pc2_q[PC_LO_OUT]))
    else $error("master-in pin drive wrong");
  a_transmit_output_enable_off_quiet: assert property ($stable(cfg) && mst && !ctl_q[CTL_TRANSMIT_OUTPUT_ENABLE_BIT] && pc2_q[PC_HI_FN]
    |-> !mosi_pin_oe) else $error("output driven with transmit_output_enable off");
  a_master_clock_start: assert property (done_wr && avs_address == ADDR_SHIFT && mst && pc1_q[PC_LO_FN]
    |-> ##[1:12] clk_pin_out) else $error("no serial clock after write");
  // Main scenarios
  c_master_write: cover property (done_wr && avs_address == ADDR_SHIFT && mst);
  c_rx_read: cover property (avs_read && !avs_waitrequest && avs_address == ADDR_RX_BUF);
  c_sel_gpio: cover property (mst && sel_pin_oe);
  c_slave_transmit_output_enable: cover property (!mst && miso_pin_oe);
endmodule : spipc_properties
bind spipc_top spipc_properties spipc_properties_i (.core_clk(core_clk), .rst(rst), .ce(ce),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sel_pin_out(sel_pin_out), .sel_pin_oe(sel_pin_oe), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
  .mosi_pin_out(mosi_pin_out), .mosi_pin_oe(mosi_pin_oe), .miso_pin_out(miso_pin_out), .miso_pin_oe(miso_pin_oe));

// ---- tb/spipc_peer.sv ----
// External serial peer: samples data on rising clock, shifts its byte on falling clock.
// Assumes the clock idles low and the bench pulses load before each frame.
`timescale 1ns/1ps
module spipc_peer (
  // Link
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // Bench control
  input wire logic load,
  input wire logic en,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [7:0] tx_sr = 8'h00; // Outgoing bits, MSB on the line
  // First bit stands before the first rising edge; fill changes so no stale bit
  always @(posedge load or negedge sclk) begin
    if (load) tx_sr <= tx_byte; // Whole left-justified bytes
    else tx_sr <= {tx_sr[6:0], ~tx_sr[7]};
  end
  // Collect what the master sends, MSB first
  always @(posedge sclk) rx_byte <= {rx_byte[6:0], mosi};
  // Released line shows the inverse rather than the last bit
  assign miso = en ? tx_sr[7] : ~tx_sr[7];
endmodule : spipc_peer

// ---- tb/spipc_top_bench.sv ----
// Bench: register accesses over Avalon-MM, pin checks and master transfers with a peer.
// Assumes the design package and spipc_top; ce and byteenable are tied.
`timescale 1ns/1ps
module spipc_top_bench
  import spipc_pkg::*;
;
  logic core_clk = 1'h0; // 20 MHz
  logic rst = 1'h1; // Held for 8 cycles
  logic [ADDR_W-1:0] avs_address = 17'h0;
  logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic sel_pin_out, sel_pin_oe, clk_pin_out, clk_pin_oe;
  logic mosi_pin_out, mosi_pin_oe, miso_pin_out, miso_pin_oe;
  logic sel_pad = 1'h1, clk_pad = 1'h0, mosi_pad = 1'h1; // Far-side levels when undriven
  logic sel_w, clk_w, mosi_w, miso_w, peer_miso; // Resolved pin levels
  logic peer_load = 1'h0, peer_en = 1'h0;
  logic [7:0] peer_tx = 8'h00, peer_rx;
  int n_errors = 0;
  int checks_done = 0;
  assign sel_w = sel_pin_oe ? sel_pin_out : sel_pad;
  assign clk_w = clk_pin_oe ? clk_pin_out : clk_pad;
  assign mosi_w = mosi_pin_oe ? mosi_pin_out : mosi_pad;
  assign miso_w = miso_pin_oe ? miso_pin_out : peer_miso;
  always #25 core_clk = ~core_clk;
  spipc_top spipc_top_i (.core_clk(core_clk), .rst(rst), .ce(1'h1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sel_pin_in(sel_w),
    .sel_pin_out(sel_pin_out), .sel_pin_oe(sel_pin_oe), .clk_pin_in(clk_w), .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe), .mosi_pin_in(mosi_w), .mosi_pin_out(mosi_pin_out), .mosi_pin_oe(mosi_pin_oe),
    .miso_pin_in(miso_w), .miso_pin_out(miso_pin_out), .miso_pin_oe(miso_pin_oe));
  spipc_peer spipc_peer_i (.sclk(clk_w), .mosi(mosi_w), .miso(peer_miso), .load(peer_load),
    .en(peer_en), .tx_byte(peer_tx), .rx_byte(peer_rx));
  // Compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask : chk
  // One bus access; held until waitrequest is sampled low
  task automatic acc(input logic we, input logic [ADDR_W-1:0] a, input logic [7:0] wd, output logic [7:0] rd);
    int k;
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= !we;
    avs_write <= we;
    avs_writedata <= {24'h0, wd};
    for (k = 0; k < 16; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'h0) break;
    end
    rd = avs_readdata[7:0];
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (k == 16) begin
      chk("bus answer", 8'h0, 8'h1);
      wrap_up();
    end
  endtask : acc
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] v;
    acc(1'h1, a, d, v);
  endtask : wr
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] want, input string what);
    logic [7:0] v;
    acc(1'h0, a, 8'h00, v);
    chk(what, v, want);
  endtask : rd_chk
  // Pin registers plus two-flop sync need a few cycles
  task automatic settle();
    repeat (4) @(posedge core_clk);
  endtask : settle
  // One master character; peer answers with ptx
  task automatic xfer(input logic [7:0] ctl, input logic [7:0] tx, input logic [7:0] ptx, input logic transmit_output_enable);
    logic [7:0] v;
    int k;
    wr(ADDR_CONTROL, ctl);
    peer_tx <= ptx;
    peer_load <= 1'h1;
    @(posedge core_clk);
    peer_load <= 1'h0;
    wr(ADDR_SHIFT, tx);
    settle();
    chk("clock drive", clk_pin_oe, 8'h1);
    chk("data drive", mosi_pin_oe, {7'h0, transmit_output_enable});
    for (k = 0; k < 60; k++) begin
      acc(1'h0, ADDR_STATUS, 8'h00, v);
      if (v[STS_DONE_BIT] === 1'h1) break;
    end
    chk("done flag", v, 8'h40);
    if (k == 60) wrap_up();
    rd_chk(ADDR_RX_BUF, ptx, "receive buffer");
    rd_chk(ADDR_STATUS, 8'h00, "done after read");
    if (transmit_output_enable) chk("peer byte", peer_rx, tx);
    $display("test transfer %h done", tx);
  endtask : xfer
  // One slave character; bench is link master and samples late in the high half, since the slave lags by its sync
  task automatic slave_xfer(input logic [7:0] tx, input logic [7:0] mbyte);
    logic [7:0] got;
    int b;
    wr(ADDR_CONTROL, 8'h02);
    wr(ADDR_PC_SEL_CLK, 8'h22);
    wr(ADDR_PC_DATA, 8'h22);
    sel_pad <= 1'h0;
    settle();
    chk("slave data drive", miso_pin_oe, 8'h1);
    chk("module select drive", sel_pin_oe, 8'h0);
    wr(ADDR_SHIFT, tx);
    for (b = 7; b >= 0; b--) begin
      mosi_pad <= mbyte[b];
      repeat (4) @(posedge core_clk);
      clk_pad <= 1'h1;
      repeat (4) @(posedge core_clk);
      got[b] = miso_w;
      clk_pad <= 1'h0;
    end
    settle();
    rd_chk(ADDR_STATUS, 8'h40, "slave done");
    rd_chk(ADDR_RX_BUF, mbyte, "slave receive");
    chk("slave out", got, tx);
    sel_pad <= 1'h1;
    $display("test slave transfer %h done", tx);
  endtask : slave_xfer
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'h0;
    rd_chk(ADDR_CONTROL, 8'h00, "role after reset");
    rd_chk(ADDR_PC_SEL_CLK, 8'h80, "pin ctl 1 reset");
    rd_chk(ADDR_PC_DATA, 8'h88, "pin ctl 2 reset");
    rd_chk(ADDR_SHIFT - 17'h4, 8'h00, "unmapped read");
    $display("test reset done");
    // Slave: module select and serial clock never driven; level bits ignore writes
    wr(ADDR_PC_SEL_CLK, 8'hFF);
    settle();
    chk("select drive", sel_pin_oe, 8'h0);
    chk("slave clock drive", clk_pin_oe, 8'h0);
    rd_chk(ADDR_PC_SEL_CLK, 8'hF7, "pin ctl 1 levels");
    wr(ADDR_PC_SEL_CLK, 8'h11);
    settle();
    chk("select out", {sel_pin_oe, sel_pin_out}, 8'h2);
    chk("clock out", {clk_pin_oe, clk_pin_out}, 8'h2);
    rd_chk(ADDR_PC_SEL_CLK, 8'h11, "live low levels");
    wr(ADDR_PC_DATA, 8'h55);
    settle();
    chk("data pins", {mosi_pin_oe, mosi_pin_out, miso_pin_oe, miso_pin_out}, 8'hF);
    rd_chk(ADDR_PC_DATA, 8'hDD, "pin ctl 2 levels");
    $display("test pin control done");
    // Master: select stays general I/O whatever its function bit
    wr(ADDR_CONTROL, 8'h04);
    wr(ADDR_PC_SEL_CLK, 8'h72);
    settle();
    chk("master select", {sel_pin_oe, sel_pin_out}, 8'h3);
    chk("clock idle", {clk_pin_oe, clk_pin_out}, 8'h2);
    wr(ADDR_PC_DATA, 8'h20);
    peer_en <= 1'h1;
    $display("test master select done");
    xfer(8'h06, 8'h3C, 8'hA5, 1'h1);
    xfer(8'h04, 8'h00, 8'h5A, 1'h0); // Dummy write to receive
    slave_xfer(8'hC3, 8'h96);
    wrap_up();
  end
endmodule : spipc_top_bench
